// *** src/sxi_serial_init.v ***
`timescale 1ns/1ns
// How it works
// - sample sideband inputs on falling serial clock
// - reset and chain sideband wires are low-true; serial clock is not inverted
// - reset sampled one loads reset values
// - chain output one, one cycle after reset
// - chain output zero one cycle after input
// - count release-to-chain-zero cycles into identifier
// - identifier 0..63 equals chain position
// - far-end chain input always reads zero
// - chain output feeds next device toward controller
// - reset places device in low power
// - directed accesses need matching identifier
// - each pattern byte shifts holding register eight
// - received words land in scrambled core order
// - commit writes sub-column chosen by width
// - broadcast write of exit bit leaves low power
`include "sxi_map.vh"

module sxi_serial_init (
  // clock and reset
  input wire CLK,
  input wire SRST,
  // serial sideband pins, reset and chain low-true on the wire
  input wire SCK,
  input wire RST_N,
  input wire CHAIN_INPUT_N,
  output reg CHAIN_OUTPUT_N,
  // enumeration and power status
  output reg [5:0] SERIAL_IDENTIFIER_FIELD,
  output reg SERIAL_IDENTIFIER_VALID,
  output reg LOW_POWER,
  // decoded serial requests
  input wire REQ_VALID,
  input wire REQ_BCAST,
  input wire REQ_WRITE,
  input wire [5:0] REQ_ID,
  input wire [7:0] REQ_ADDR,
  input wire [7:0] REQ_WDATA,
  output reg REQ_HIT,
  // pattern byte load
  input wire PATTERN_BYTE_LOAD_VALID,
  input wire [7:0] PATTERN_BYTE_LOAD_DATA,
  output reg PATTERN_COLUMN_FULL,
  // column commit
  input wire COMMIT_VALID,
  input wire [2:0] WIDTH_MODE,
  input wire [3:0] SUBCOLUMN_SELECT,
  output reg [15:0] CORE_WORD_WE,
  output reg [255:0] CORE_WORD_DATA
);

  // ----------------------------------------
  // enumeration states
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_RESET = 2'h1;
  localparam [1:0] ST_COUNT = 2'h2;
  localparam [1:0] ST_DONE = 2'h3;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [2:0] pin_raw;
  wire [2:0] pin_s;
  assign pin_raw = {SCK, RST_N, CHAIN_INPUT_N};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      sxi_sync u_sync (
        .clk(CLK),
        .srst(SRST),
        .d_in(pin_raw[g]),
        .q_out(pin_s[g])
      );
    end
  endgenerate

  reg sck_d_r;
  wire sck_fall;
  wire rst_asserted;
  wire chain_in_asserted;
  // sck falling edge is the only sample point; wires inverted to logical ones
  assign sck_fall = sck_d_r & ~pin_s[2];
  assign rst_asserted = ~pin_s[1];
  assign chain_in_asserted = ~pin_s[0];

  always @(posedge CLK) begin
    if (SRST) begin
      sck_d_r <= 1'b0;
    end else begin
      sck_d_r <= pin_s[2];
    end
  end

  // ----------------------------------------
  // enumeration state machine
  // ----------------------------------------
  reg [1:0] state_r;
  reg rst_prev_r;
  reg chain_prev_r;
  reg chain_out_r;
  reg [5:0] cnt_r;
  reg [5:0] id_r;
  reg id_valid_r;
  reg low_power_r;
  reg pm_exit;

  always @(posedge CLK) begin
    if (SRST) begin
      state_r <= ST_IDLE;
      rst_prev_r <= 1'b0;
      chain_prev_r <= 1'b0;
      chain_out_r <= 1'b0;
      cnt_r <= 6'h00;
      id_r <= `SXI_ID_RESET;
      id_valid_r <= 1'b0;
      low_power_r <= `SXI_LOW_POWER_RESET;
    end else begin
      if (pm_exit)
        low_power_r <= 1'b0;
      if (sck_fall) begin
        rst_prev_r <= rst_asserted;
        chain_prev_r <= chain_in_asserted;
        // output lags what was sampled one edge earlier
        if (rst_prev_r)
          chain_out_r <= 1'b1;
        else if (state_r != ST_IDLE)
          chain_out_r <= chain_prev_r;
        if (rst_asserted) begin
          // reset wins over any pending exit request
          state_r <= ST_RESET;
          cnt_r <= 6'h00;
          id_r <= `SXI_ID_RESET;
          id_valid_r <= 1'b0;
          low_power_r <= `SXI_LOW_POWER_RESET;
        end else begin
          case (state_r)
            ST_IDLE: begin
              state_r <= ST_IDLE;
            end
            ST_RESET, ST_COUNT: begin
              // far-end device sees chain low on release edge: count 0
              if (!chain_in_asserted) begin
                id_r <= cnt_r;
                id_valid_r <= 1'b1;
                state_r <= ST_DONE;
              end else begin
                state_r <= ST_COUNT;
                if (cnt_r != `SXI_ID_MAX)
                  cnt_r <= cnt_r + 6'h01;
              end
            end
            ST_DONE: begin
              state_r <= ST_DONE;
            end
            default: begin
              state_r <= ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // request decode and powerdown exit
  // ----------------------------------------
  reg hit;

  always @* begin
    hit = REQ_VALID & (REQ_BCAST | (id_valid_r & (REQ_ID == id_r)));
    pm_exit = hit & REQ_WRITE & (REQ_ADDR == `SXI_PM_ADDR) &
      REQ_WDATA[`SXI_PX_BIT];
  end

  // ----------------------------------------
  // pattern holding shifter
  // ----------------------------------------
  reg [255:0] hold_r;
  reg [5:0] byte_cnt_r;

  always @(posedge CLK) begin
    if (SRST) begin
      hold_r <= 256'h0;
      byte_cnt_r <= 6'h00;
    end else if (sck_fall && rst_asserted) begin
      byte_cnt_r <= 6'h00;
    end else if (PATTERN_BYTE_LOAD_VALID) begin
      hold_r <= {hold_r[247:0], PATTERN_BYTE_LOAD_DATA};
      if (byte_cnt_r != `SXI_COL_BYTES)
        byte_cnt_r <= byte_cnt_r + 6'h01;
    end
  end

  // received word n is oldest-first; bytes carry bits in interleaved order
  function integer core_of;
    input integer n;
    begin
      case (n)
        0: core_of = 15;
        1: core_of = 7;
        2: core_of = 11;
        3: core_of = 3;
        4: core_of = 13;
        5: core_of = 5;
        6: core_of = 9;
        7: core_of = 1;
        8: core_of = 0;
        9: core_of = 8;
        10: core_of = 4;
        11: core_of = 12;
        12: core_of = 2;
        13: core_of = 10;
        14: core_of = 6;
        default: core_of = 14;
      endcase
    end
  endfunction

  wire [255:0] core_col;
  genvar gn;
  genvar gi;
  generate
    for (gn = 0; gn < 16; gn = gn + 1) begin : g_word
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_bit
        assign core_col[16 * core_of(gn) + 15 - 4 * (gi % 4) - gi / 4] =
          hold_r[255 - 16 * gn - gi];
      end
    end
  endgenerate

  // ----------------------------------------
  // sub-column commit
  // ----------------------------------------
  reg [15:0] we_mask;

  always @* begin
    case (WIDTH_MODE)
      `SXI_WIDTH_X16: we_mask = 16'hFFFF;
      `SXI_WIDTH_X8: we_mask = SUBCOLUMN_SELECT[3] ? 16'hFF00 : 16'h00FF;
      `SXI_WIDTH_X4: begin
        case (SUBCOLUMN_SELECT[3:2])
          2'h0: we_mask = 16'h000F;
          2'h1: we_mask = 16'h00F0;
          2'h2: we_mask = 16'h0F00;
          default: we_mask = 16'hF000;
        endcase
      end
      default: we_mask = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  always @(posedge CLK) begin
    if (SRST) begin
      CHAIN_OUTPUT_N <= 1'b1;
      SERIAL_IDENTIFIER_FIELD <= `SXI_ID_RESET;
      SERIAL_IDENTIFIER_VALID <= 1'b0;
      LOW_POWER <= `SXI_LOW_POWER_RESET;
      REQ_HIT <= 1'b0;
      PATTERN_COLUMN_FULL <= 1'b0;
      CORE_WORD_WE <= 16'h0000;
      CORE_WORD_DATA <= 256'h0;
    end else begin
      CHAIN_OUTPUT_N <= ~chain_out_r;
      SERIAL_IDENTIFIER_FIELD <= id_r;
      SERIAL_IDENTIFIER_VALID <= id_valid_r;
      LOW_POWER <= low_power_r;
      REQ_HIT <= hit;
      PATTERN_COLUMN_FULL <= (byte_cnt_r == `SXI_COL_BYTES);
      CORE_WORD_WE <= COMMIT_VALID ? we_mask : 16'h0000;
      if (COMMIT_VALID)
        CORE_WORD_DATA <= core_col;
    end
  end

endmodule // sxi_serial_init

// *** src/sxi_map.vh ***
`ifndef SXI_MAP_VH
`define SXI_MAP_VH

// ----------------------------------------
// enumeration
// ----------------------------------------
`define SXI_ID_W 6
`define SXI_ID_RESET 6'h00
`define SXI_ID_MAX 6'h3F
`define SXI_RST_HOLD_MIN 2
`define SXI_MIN_ENUM_EDGES 20

// ----------------------------------------
// power management register
// ----------------------------------------
`define SXI_PM_ADDR 8'h03
`define SXI_PX_BIT 0
`define SXI_LOW_POWER_RESET 1'b1

// ----------------------------------------
// pattern load and width modes
// ----------------------------------------
`define SXI_COL_BITS 256
`define SXI_COL_BYTES 6'h20
`define SXI_WIDTH_X4 3'h2
`define SXI_WIDTH_X8 3'h3
`define SXI_WIDTH_X16 3'h4

`endif

// *** src/sxi_sync.v ***
`timescale 1ns/1ns
// two-flop synchroniser for one pin; first stage feeds only the second
module sxi_sync (
  // clock and reset
  input wire clk,
  input wire srst,
  // pin and synchronised level
  input wire d_in,
  output reg q_out
);

  reg meta_r;

  always @(posedge clk) begin
    if (srst) begin
      meta_r <= 1'b0;
      q_out <= 1'b0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end

endmodule // sxi_sync

// *** tb/sxi_serial_init_asserts.sv ***
`timescale 1ns/1ns
module sxi_serial_init_asserts (
  // clock and reset
  input wire CLK,
  input wire SRST,
  // requests
  input wire REQ_VALID,
  input wire REQ_BCAST,
  input wire REQ_WRITE,
  input wire [5:0] REQ_ID,
  input wire [7:0] REQ_ADDR,
  input wire [7:0] REQ_WDATA,
  input wire REQ_HIT,
  // status
  input wire [5:0] SERIAL_IDENTIFIER_FIELD,
  input wire SERIAL_IDENTIFIER_VALID,
  input wire LOW_POWER,
  // commit
  input wire COMMIT_VALID,
  input wire [2:0] WIDTH_MODE,
  input wire [3:0] SUBCOLUMN_SELECT,
  input wire [15:0] CORE_WORD_WE
);
  // ----
  // properties
  // ----
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence s_exit;
    REQ_VALID && REQ_BCAST && REQ_WRITE && REQ_ADDR == 8'h03 && REQ_WDATA[0];
  endsequence
  sequence s_miss;
    REQ_VALID && !REQ_BCAST && (REQ_ID != SERIAL_IDENTIFIER_FIELD || !SERIAL_IDENTIFIER_VALID);
  endsequence
  a_bcast_hit: assert property (REQ_VALID && REQ_BCAST |=> REQ_HIT)
    else $error("broadcast not accepted");
  a_id_miss: assert property (s_miss |=> !REQ_HIT)
    else $error("foreign request accepted");
  a_hit_cause: assert property (REQ_HIT |-> $past(REQ_VALID))
    else $error("hit without request");
  a_exit_wake: assert property (s_exit |-> ##2 !LOW_POWER)
    else $error("exit write left low power");
  a_we_full: assert property (COMMIT_VALID && WIDTH_MODE == 3'h4
    |=> CORE_WORD_WE == 16'hFFFF)
    else $error("x16 commit enables wrong");
  a_we_half: assert property (COMMIT_VALID && WIDTH_MODE == 3'h3
    && !SUBCOLUMN_SELECT[3] |=> CORE_WORD_WE == 16'h00FF)
    else $error("x8 low commit enables wrong");
  a_we_upper: assert property (COMMIT_VALID && WIDTH_MODE == 3'h3
    && SUBCOLUMN_SELECT[3] |=> CORE_WORD_WE == 16'hFF00)
    else $error("x8 high commit enables wrong");
  a_we_quad: assert property (COMMIT_VALID && WIDTH_MODE == 3'h2
    |=> CORE_WORD_WE == 16'h000F << ($past(SUBCOLUMN_SELECT) & 4'hC))
    else $error("x4 commit enables wrong");
  a_we_cause: assert property (CORE_WORD_WE != 16'h0000 |-> $past(COMMIT_VALID))
    else $error("write enable without commit");
  a_id_hold: assert property (SERIAL_IDENTIFIER_VALID
    && $past(SERIAL_IDENTIFIER_VALID) |-> $stable(SERIAL_IDENTIFIER_FIELD))
    else $error("identifier changed while valid");
endmodule // sxi_serial_init_asserts

bind sxi_serial_init sxi_serial_init_asserts i_chk (.CLK, .SRST, .REQ_VALID, .REQ_BCAST,
  .REQ_WRITE, .REQ_ID, .REQ_ADDR, .REQ_WDATA, .REQ_HIT, .SERIAL_IDENTIFIER_FIELD,
  .SERIAL_IDENTIFIER_VALID, .LOW_POWER, .COMMIT_VALID, .WIDTH_MODE, .SUBCOLUMN_SELECT,
  .CORE_WORD_WE);

// *** tb/sxi_ctrl_model.sv ***
`timescale 1ns/1ns
module sxi_ctrl_model (
  // pacing clock
  input wire clk,
  // sideband toward the device
  output reg sck = 1'b1,
  output reg rst_n = 1'b1,
  output reg chain_n = 1'b1,
  // chain output from the device
  input wire chain_out_n
);
  // ----
  // enumeration frame
  // ----
  reg [79:0] seen;
  // k upstream devices; clock stands high between frames
  task enumerate(input integer k);
    integer c;
    begin
      seen = {80{1'b1}};
      for (c = 0; c < k + 12 || c < 26; c = c + 1) begin
        rst_n = !(c == 4 || c == 5);
        chain_n = !(k > 0 && c >= 5 && c < 6 + k);
        repeat (4) @(negedge clk);
        seen[c] = chain_out_n;
        sck = 1'b0;
        repeat (4) @(negedge clk);
        sck = 1'b1;
      end
    end
  endtask
  // ----
  // bring-up commands
  // ----
  // only sequenced here; the block decodes none of them
  // op 1 termination start, 2 current start, 3 end
  reg [1:0] cal_op = 2'h0;
  reg [2:0] refresh_row_counter = 3'h0;
  reg [2:0] bank = 3'h0;
  task bring_up;
    integer j;
    begin
      for (j = 0; j < 512; j = j + 1) begin
        @(negedge clk);
        cal_op = j[0] ? 2'h3 : (j < 256) ? 2'h1 : 2'h2;
      end
      // banks interleaved, eight successive rows each
      for (j = 0; j < 64; j = j + 1) begin
        @(negedge clk);
        {refresh_row_counter, bank} = j[5:0];
      end
      @(negedge clk);
      cal_op = 2'h0;
    end
  endtask
endmodule // sxi_ctrl_model

// *** tb/tb_sxi_serial_init.sv ***
`timescale 1ns/1ns
module tb_sxi_serial_init;
  // ----
  // bench state
  // ----
  localparam [63:0] MAP = 64'hF7B3D591084C2A6E;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg rv = 1'b0, rb = 1'b0, pv = 1'b0, cv = 1'b0, rw = 1'b1;
  reg [5:0] rid = 6'h00;
  reg [7:0] rd = 8'h00, pd = 8'h00, pb, ra = 8'h03;
  reg [2:0] wm = 3'h0;
  reg [3:0] sc = 4'h0;
  wire sck, rst_n, chain_n, cout_n, idv, lp, hit, full;
  wire [5:0] id;
  wire [15:0] we;
  wire [255:0] cdata;
  integer err_total = 0, n_checks = 0, cycles = 0, i, k, c;
  reg [255:0] exp_col = 256'h0;
  reg [79:0] exp_seen;
  always #25 clk = ~clk;
  sxi_ctrl_model i_ctl (.clk(clk), .sck(sck), .rst_n(rst_n), .chain_n(chain_n),
    .chain_out_n(cout_n));
  sxi_serial_init i_dut (.CLK(clk), .SRST(srst), .SCK(sck), .RST_N(rst_n),
    .CHAIN_INPUT_N(chain_n), .CHAIN_OUTPUT_N(cout_n), .SERIAL_IDENTIFIER_FIELD(id),
    .SERIAL_IDENTIFIER_VALID(idv), .LOW_POWER(lp), .REQ_VALID(rv), .REQ_BCAST(rb),
    .REQ_WRITE(rw), .REQ_ID(rid), .REQ_ADDR(ra), .REQ_WDATA(rd), .REQ_HIT(hit),
    .PATTERN_BYTE_LOAD_VALID(pv), .PATTERN_BYTE_LOAD_DATA(pd), .PATTERN_COLUMN_FULL(full),
    .COMMIT_VALID(cv), .WIDTH_MODE(wm), .SUBCOLUMN_SELECT(sc), .CORE_WORD_WE(we),
    .CORE_WORD_DATA(cdata));
  task chk(input [255:0] exp, input [255:0] got, input [47:0] what);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("MISMATCH %0s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // hang guard, far above the ~1700 cycles the run needs
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      err_total = err_total + 1;
      give_verdict;
    end
  end
  task req(input b, input [5:0] t, input [7:0] d, input exp_hit);
    begin
      @(negedge clk);
      {rv, rb, rid, rd} = {1'b1, b, t, d};
      @(negedge clk);
      rv = 1'b0;
      chk(exp_hit, hit, "hit");
    end
  endtask
  task commit(input [2:0] w, input [3:0] s, input [15:0] exp_we);
    begin
      @(negedge clk);
      {cv, wm, sc} = {1'b1, w, s};
      @(negedge clk);
      cv = 1'b0;
      chk(exp_we, we, "we");
    end
  endtask
  function [15:0] word(input [7:0] b0, input [7:0] b1);
    integer j;
    begin
      for (j = 0; j < 4; j = j + 1) begin
        word[15 - 4 * j] = b0[7 - j];
        word[14 - 4 * j] = b0[3 - j];
        word[13 - 4 * j] = b1[7 - j];
        word[12 - 4 * j] = b1[3 - j];
      end
    end
  endfunction
  // ----
  // main sequence
  // ----
  initial begin
    repeat (16) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    chk(3'b110, {lp, cout_n, idv}, "rst");
    req(1'b0, 6'h00, 8'h00, 1'b0);
    for (i = 0; i < 3; i = i + 1) begin
      k = (i == 0) ? 0 : (i == 1) ? 4 : 63;
      i_ctl.enumerate(k);
      repeat (2) @(negedge clk);
      exp_seen = {80{1'b1}};
      for (c = 6; c <= 7 + k; c = c + 1)
        exp_seen[c] = 1'b0;
      chk(exp_seen, i_ctl.seen, "chain");
      chk({1'b1, k[5:0]}, {idv, id}, "id");
      chk(1'b1, lp, "lowpwr");
      req(1'b0, k[5:0] + 6'h01, 8'h00, 1'b0);
      req(1'b0, k[5:0], 8'h00, 1'b1);
      ra = 8'h02;
      req(1'b1, 6'h2A, 8'h01, 1'b1);
      {rw, ra} = {1'b0, 8'h03};
      req(1'b1, 6'h2A, 8'h01, 1'b1);
      rw = 1'b1;
      @(negedge clk);
      chk(1'b1, lp, "lowpwr");
      req(1'b1, 6'h2A, 8'h01, 1'b1);
      @(negedge clk);
      chk(1'b0, lp, "lowpwr");
    end
    i_ctl.bring_up;
    for (i = 0; i < 32; i = i + 1) begin
      @(negedge clk);
      pb = pd;
      pv = 1'b1;
      pd = i[7:0] * 8'h1D + 8'h35;
      if (i % 2 == 1)
        exp_col[16 * MAP[63 - 4 * (i / 2) -: 4] +: 16] = word(pb, pd);
    end
    @(negedge clk);
    pv = 1'b0;
    chk(1'b0, full, "full");
    repeat (2) @(negedge clk);
    chk(1'b1, full, "full");
    commit(3'h4, 4'h0, 16'hFFFF);
    chk(exp_col, cdata, "data");
    commit(3'h3, 4'h7, 16'h00FF);
    commit(3'h3, 4'h8, 16'hFF00);
    for (i = 0; i < 4; i = i + 1)
      commit(3'h2, {i[1:0], 2'h1}, 16'h000F << (4 * i));
    commit(3'h0, 4'h0, 16'h0000);
    give_verdict;
  end
endmodule // tb_sxi_serial_init
